// ---- rtl/host_port_pkg.sv ----
// Shared constants and types for the host port control register and its host
`default_nettype none
package host_port_pkg;

// ----------------------------------------
// Link register select codes
// ----------------------------------------
localparam logic [1:0] SEL_CTRL = 2'h0;
localparam logic [1:0] SEL_ADDR = 2'h1;
localparam logic [1:0] SEL_DATA_INC = 2'h2;
localparam logic [1:0] SEL_DATA = 2'h3;

// ----------------------------------------
// Control register layout (one halfword)
// ----------------------------------------
localparam int ORDER_BIT = 0;
localparam int H2C_BIT = 1;
localparam int C2H_BIT = 2;
localparam int READY_BIT = 3;
localparam int FETCH_BIT = 4;
localparam logic [15:0] CTRL_WR_MASK = 16'h0017;
localparam logic ORDER_RST = 1'b0;
localparam logic H2C_RST = 1'b0;
localparam logic C2H_RST = 1'b0;
localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

// ----------------------------------------
// Host controller APB map
// ----------------------------------------
localparam logic [7:0] OFS_CMD = 8'h00;
localparam logic [7:0] OFS_WDATA = 8'h04;
localparam logic [7:0] OFS_RDATA = 8'h08;
localparam logic [7:0] OFS_STATUS = 8'h0c;
localparam logic [7:0] OFS_CONFIG = 8'h10;
localparam int CMD_SEL_LSB = 0;
localparam int CMD_WE_BIT = 2;
localparam int CMD_SECOND_BIT = 3;
localparam int CFG_FULL_BIT = 0;
localparam int CFG_CS_BIT = 1;
localparam int ST_BUSY_BIT = 0;
localparam int ST_READY_BIT = 1;
localparam int ST_IRQ_BIT = 2;
localparam logic [31:0] CONFIG_RST = 32'h0000_0000;

typedef enum logic [1:0] {PH_IDLE, PH_STROBE, PH_CAPTURE} host_phase_t;

endpackage
`default_nettype wire

// ---- rtl/host_port_if.sv ----
// Link between the external host and the device's host port
`timescale 1ns/1ps
`default_nettype none
interface host_port_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic host_chip_select;
    logic full_width_mode;
    logic strobe;
    logic write_en;
    logic second_half;
    logic [1:0] reg_sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic host_ready;
    logic device_to_host_irq_n;

    modport dev (
        input pclk, presetn, host_chip_select, full_width_mode, strobe,
        input write_en, second_half, reg_sel, wdata,
        output rdata, host_ready, device_to_host_irq_n
    );
    modport host (
        input pclk, presetn, rdata, host_ready, device_to_host_irq_n,
        output host_chip_select, full_width_mode, strobe, write_en,
        output second_half, reg_sel, wdata
    );
endinterface
`default_nettype wire

// ---- rtl/halfword_lane.sv ----
// Halfword ordering for one 32-bit host-visible word
`timescale 1ns/1ps
`default_nettype none
module halfword_lane (
    input wire logic [31:0] word,
    input wire logic lsb_first,
    input wire logic full_width_mode,
    input wire logic second_half,
    input wire logic [31:0] new_word,
    input wire logic [15:0] held_half,
    output logic [31:0] read_word,
    output logic [31:0] write_word
);
    logic msb_now;

    always_comb begin
        // Order bit is simply unused in full width
        msb_now = lsb_first ? second_half : !second_half;
        if (full_width_mode) begin
            read_word = word;
            write_word = new_word;
        end else begin
            read_word = {16'h0000, msb_now ? word[31:16] : word[15:0]};
            write_word = lsb_first ? {new_word[15:0], held_half} : {held_half, new_word[15:0]};
        end
    end
endmodule
`default_nettype wire

// ---- rtl/host_port_device.sv ----
// Device end: control register, address/data registers and access engine
// Summary of operation
// - Reserved control bits always read zero
// - Host writes zero to writable reserved bits
// - Fetch bit write starts prefetch, reads zero
// - Ready bit low while access pending, unmasked
// - Interrupt pin is inverse of its bit
// - Order bit chooses which halfword comes first
// - Only host sets order, before first access
// - Full width mode ignores the order bit
// - Ready pin low while data access pending and selected
// - Host read: poll, address, fetch, poll, read
// - Postincrement read resumes at second poll
// - Host write: poll, address, then data
// - Host one sets host-to-core interrupt bit
// - Core one on clear interrupt does nothing
// - Core one on set interrupt clears it
// - Zero never changes host-to-core interrupt
// - Core one sets device-to-host interrupt
// - Host one clears device-to-host interrupt
// - Zero never changes device-to-host interrupt
// - Each half read samples interrupt bit afresh
// - Host sees control as two identical halves
// - Core writes only affect the lower halfword
// - Half mode: host sets interrupt in one half
`timescale 1ns/1ps
`default_nettype none
module host_port_device (
    host_port_if.dev link,
    input wire logic cpu_wr,
    input wire logic [3:0] cpu_wstrb,
    input wire logic [31:0] cpu_wdata,
    output logic [31:0] cpu_rdata,
    output logic host_to_core_irq,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic order;
        logic h2c;
        logic c2h;
        logic busy;
        logic wr_pend;
        logic inc;
        logic [31:0] addr;
        logic [31:0] data;
        logic [15:0] hold;
        logic [31:0] rdata;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;

    logic [15:0] ctrl_half;
    logic [15:0] w16;
    logic acc;
    logic host_wr;
    logic host_rd;
    logic last_half;
    logic ctrl_wr;
    logic cpu_lo;
    logic host_set_h2c;
    logic host_clr_c2h;
    logic cpu_clr_h2c;
    logic cpu_set_c2h;
    logic [31:0] addr_rd;
    logic [31:0] addr_wr;
    logic [31:0] data_rd;
    logic [31:0] data_wr;

    // ----------------------------------------
    // Halfword ordering
    // ----------------------------------------
    halfword_lane addr_lane (
        .word(s_q.addr),
        .lsb_first(s_q.order),
        .full_width_mode(link.full_width_mode),
        .second_half(link.second_half),
        .new_word(link.wdata),
        .held_half(s_q.hold),
        .read_word(addr_rd),
        .write_word(addr_wr)
    );

    halfword_lane data_lane (
        .word(s_q.data),
        .lsb_first(s_q.order),
        .full_width_mode(link.full_width_mode),
        .second_half(link.second_half),
        .new_word(link.wdata),
        .held_half(s_q.hold),
        .read_word(data_rd),
        .write_word(data_wr)
    );

    // Fetch bit and reserved bits are never stored
    function automatic logic [15:0] ctrl_view(input dev_state_t s);
        logic [15:0] v;
        v = 16'h0000;
        v[host_port_pkg::ORDER_BIT] = s.order;
        v[host_port_pkg::H2C_BIT] = s.h2c;
        v[host_port_pkg::C2H_BIT] = s.c2h;
        v[host_port_pkg::READY_BIT] = !s.busy;
        return v;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        ctrl_half = ctrl_view(s_q);
        acc = link.strobe && link.host_chip_select;
        host_wr = acc && link.write_en;
        host_rd = acc && !link.write_en;
        last_half = link.full_width_mode || link.second_half;
        ctrl_wr = host_wr && (link.reg_sel == host_port_pkg::SEL_CTRL);
        // Halves are identical, so the low half carries the write
        w16 = link.wdata[15:0];
        cpu_lo = cpu_wr && cpu_wstrb[0];
        host_set_h2c = ctrl_wr && w16[host_port_pkg::H2C_BIT];
        host_clr_c2h = ctrl_wr && w16[host_port_pkg::C2H_BIT];
        cpu_clr_h2c = cpu_lo && cpu_wdata[host_port_pkg::H2C_BIT] && s_q.h2c;
        cpu_set_c2h = cpu_lo && cpu_wdata[host_port_pkg::C2H_BIT];
        // Set wins over a clear in the same cycle
        s_d.h2c = host_set_h2c || (s_q.h2c && !cpu_clr_h2c);
        s_d.c2h = cpu_set_c2h || (s_q.c2h && !host_clr_c2h);

        if (ctrl_wr) begin
            s_d.order = w16[host_port_pkg::ORDER_BIT];
            if (w16[host_port_pkg::FETCH_BIT] && !s_q.busy) begin
                s_d.busy = 1'b1;
                s_d.wr_pend = 1'b0;
                s_d.inc = 1'b0;
            end
        end

        if (host_rd) begin
            unique case (link.reg_sel)
                host_port_pkg::SEL_CTRL: begin
                    s_d.rdata = link.full_width_mode ? {ctrl_half, ctrl_half} : {16'h0000, ctrl_half};
                end
                host_port_pkg::SEL_ADDR: begin
                    s_d.rdata = addr_rd;
                end
                host_port_pkg::SEL_DATA_INC, host_port_pkg::SEL_DATA: begin
                    s_d.rdata = data_rd;
                end
            endcase
        end

        // Address and data writes and postincrement steps are ignored while an access is pending; reads still return the register
        if (acc && !s_q.busy && (link.reg_sel != host_port_pkg::SEL_CTRL)) begin
            if (link.write_en && !last_half) begin
                s_d.hold = link.wdata[15:0];
            end else if (link.write_en && link.reg_sel == host_port_pkg::SEL_ADDR) begin
                s_d.addr = addr_wr;
            end else if (link.write_en) begin
                s_d.data = data_wr;
                s_d.busy = 1'b1;
                s_d.wr_pend = 1'b1;
                s_d.inc = link.reg_sel == host_port_pkg::SEL_DATA_INC;
            end else if (last_half && link.reg_sel == host_port_pkg::SEL_DATA_INC) begin
                // Postincrement read prefetches the next word at once
                s_d.addr = s_q.addr + host_port_pkg::ADDR_STEP;
                s_d.busy = 1'b1;
                s_d.wr_pend = 1'b0;
                s_d.inc = 1'b0;
            end
        end

        if (s_q.busy && mem_ack) begin
            s_d.busy = 1'b0;
            if (!s_q.wr_pend) begin
                s_d.data = mem_rdata;
            end
            if (s_q.inc) begin
                s_d.addr = s_q.addr + host_port_pkg::ADDR_STEP;
            end
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            s_q <= '0;
            s_q.order <= host_port_pkg::ORDER_RST;
            s_q.h2c <= host_port_pkg::H2C_RST;
            s_q.c2h <= host_port_pkg::C2H_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.rdata = s_q.rdata;
    // Pin reads ready when not selected; the status bit is not masked
    assign link.host_ready = !s_q.busy || !link.host_chip_select;
    assign link.device_to_host_irq_n = !s_q.c2h;
    assign cpu_rdata = {16'h0000, ctrl_view(s_q)};
    assign host_to_core_irq = s_q.h2c;
    assign mem_req = s_q.busy;
    assign mem_we = s_q.wr_pend;
    // Low two address bits always act as zero
    assign mem_addr = {s_q.addr[31:2], 2'b00};
    assign mem_wdata = s_q.data;
endmodule
`default_nettype wire

// ---- rtl/host_port_host.sv ----
// Host end: APB-programmed controller that drives the host port link
`timescale 1ns/1ps
`default_nettype none
module host_port_host (
    host_port_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        host_port_pkg::host_phase_t phase;
        logic [1:0] sel;
        logic we;
        logic second;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [31:0] config_r;
        logic [31:0] prdata;
    } host_state_t;

    host_state_t s_q;
    host_state_t s_d;
    logic apb_wr;
    logic [31:0] status;

    always_comb begin
        s_d = s_q;
        apb_wr = psel && penable && pwrite;
        status = 32'h0000_0000;
        status[host_port_pkg::ST_BUSY_BIT] = s_q.phase != host_port_pkg::PH_IDLE;
        // Software polls this for the handshaked sequences
        status[host_port_pkg::ST_READY_BIT] = link.host_ready;
        status[host_port_pkg::ST_IRQ_BIT] = !link.device_to_host_irq_n;

        // Read data is loaded in the setup cycle so it comes from a flop
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                host_port_pkg::OFS_WDATA: s_d.prdata = s_q.wdata;
                host_port_pkg::OFS_RDATA: s_d.prdata = s_q.rdata;
                host_port_pkg::OFS_STATUS: s_d.prdata = status;
                host_port_pkg::OFS_CONFIG: s_d.prdata = s_q.config_r;
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end

        if (apb_wr && paddr == host_port_pkg::OFS_WDATA) begin
            s_d.wdata = pwdata;
        end
        if (apb_wr && paddr == host_port_pkg::OFS_CONFIG) begin
            s_d.config_r = pwdata;
        end

        unique case (s_q.phase)
            host_port_pkg::PH_IDLE: begin
                // A command while a transfer runs is dropped
                if (apb_wr && paddr == host_port_pkg::OFS_CMD) begin
                    s_d.sel = pwdata[host_port_pkg::CMD_SEL_LSB +: 2];
                    s_d.we = pwdata[host_port_pkg::CMD_WE_BIT];
                    s_d.second = pwdata[host_port_pkg::CMD_SECOND_BIT];
                    s_d.phase = host_port_pkg::PH_STROBE;
                end
            end
            host_port_pkg::PH_STROBE: begin
                s_d.phase = host_port_pkg::PH_CAPTURE;
            end
            host_port_pkg::PH_CAPTURE: begin
                if (!s_q.we) begin
                    s_d.rdata = link.rdata;
                end
                s_d.phase = host_port_pkg::PH_IDLE;
            end
            default: s_d.phase = host_port_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            s_q <= '0;
            s_q.phase <= host_port_pkg::PH_IDLE;
            s_q.config_r <= host_port_pkg::CONFIG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign link.strobe = s_q.phase == host_port_pkg::PH_STROBE;
    assign link.write_en = s_q.we;
    assign link.second_half = s_q.second;
    assign link.reg_sel = s_q.sel;
    assign link.host_chip_select = s_q.config_r[host_port_pkg::CFG_CS_BIT];
    assign link.full_width_mode = s_q.config_r[host_port_pkg::CFG_FULL_BIT];
    // Control writes carry zeros in every reserved position of both halves
    assign link.wdata = (s_q.sel == host_port_pkg::SEL_CTRL) ?
        (s_q.wdata & {host_port_pkg::CTRL_WR_MASK, host_port_pkg::CTRL_WR_MASK}) : s_q.wdata;
endmodule
`default_nettype wire

// ---- tb/host_port_props.sv ----
// Concurrent checks on the host port link between the two ends
`timescale 1ns/1ps
`default_nettype none
module host_port_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_chip_select,
    input wire logic full_width_mode,
    input wire logic strobe,
    input wire logic write_en,
    input wire logic second_half,
    input wire logic [1:0] reg_sel,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic host_ready,
    input wire logic device_to_host_irq_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Decoded link accesses
    // ----------------------------------------
    logic go;
    logic crd;
    logic cwr;
    assign go = strobe && host_chip_select;
    assign crd = go && !write_en && reg_sel == host_port_pkg::SEL_CTRL;
    assign cwr = go && write_en && reg_sel == host_port_pkg::SEL_CTRL;
    property p_resv;
        crd |=> rdata[15:5] == 11'h000 && (!full_width_mode || rdata[31:21] == 11'h000);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved control bits not zero");
    property p_halves;
        crd && full_width_mode |=> rdata[31:16] == rdata[15:0];
    endproperty
    a_halves: assert property (p_halves) else $error("control halves differ");
    property p_irq;
        crd |=> rdata[2] == !$past(device_to_host_irq_n);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin not inverse of bit");
    property p_rdy;
        crd |=> rdata[3] == $past(host_ready);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready bit disagrees with pin");
    property p_fzero;
        crd |=> rdata[4] == 1'b0 && rdata[20] == 1'b0;
    endproperty
    a_fzero: assert property (p_fzero) else $error("fetch bit read as one");
    property p_fbusy;
        cwr && wdata[host_port_pkg::FETCH_BIT] && host_ready |=> !host_ready;
    endproperty
    a_fbusy: assert property (p_fbusy) else $error("fetch did not start");
    property p_wbusy;
        go && write_en && full_width_mode && reg_sel == host_port_pkg::SEL_DATA && host_ready |=> !host_ready;
    endproperty
    a_wbusy: assert property (p_wbusy) else $error("data write left ready high");
    property p_mask;
        !host_chip_select |-> host_ready;
    endproperty
    a_mask: assert property (p_mask) else $error("ready pin not masked by select");
    c_crd: cover property (crd);
    c_fetch: cover property (cwr && wdata[host_port_pkg::FETCH_BIT]);
    c_irq: cover property (!device_to_host_irq_n);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench: APB host end talking to the device end over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic cpu_wr = 1'b0;
    logic [3:0] cpu_wstrb = 4'h0;
    logic [31:0] cpu_wdata = 32'h0;
    logic mem_ack = 1'b0;
    logic [3:0] mcnt = 4'h0;
    logic [31:0] prdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, q, cap;
    logic pready, pslverr, host_to_core_irq, mem_req, mem_we;
    int bad_count = 0;
    int tests_run = 0;
    always #10 pclk = ~pclk;
    host_port_if lnk (.pclk(pclk), .presetn(presetn));
    host_port_host host_port_host_inst (.link(lnk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    host_port_device host_port_device_inst (.link(lnk), .cpu_wr(cpu_wr), .cpu_wstrb(cpu_wstrb),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .host_to_core_irq(host_to_core_irq), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    host_port_props host_port_props_inst (.pclk(pclk), .presetn(presetn), .host_chip_select(lnk.host_chip_select),
        .full_width_mode(lnk.full_width_mode), .strobe(lnk.strobe), .write_en(lnk.write_en),
        .second_half(lnk.second_half), .reg_sel(lnk.reg_sel), .wdata(lnk.wdata), .rdata(lnk.rdata),
        .host_ready(lnk.host_ready), .device_to_host_irq_n(lnk.device_to_host_irq_n));
    // ----------------------------------------
    // Memory side: slow on purpose so busy is observable
    // ----------------------------------------
    assign mem_rdata = mem_addr ^ 32'ha5a5_0000;
    always @(posedge pclk) begin
        mem_ack <= mem_req && !mem_ack && mcnt == 4'hc;
        mcnt <= (mem_req && !mem_ack) ? mcnt + 4'h1 : 4'h0;
        if (mem_req && mem_we) begin
            cap <= mem_wdata;
        end
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Polls host busy; the watchdog bounds a hang
    task automatic lop(input logic [1:0] sel, input logic we, input logic sec, input logic [31:0] d);
        apb(1'b1, host_port_pkg::OFS_WDATA, d);
        apb(1'b1, host_port_pkg::OFS_CMD, {28'h0, sec, we, sel});
        do apb(1'b0, host_port_pkg::OFS_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic wctl(input logic [31:0] d);
        lop(host_port_pkg::SEL_CTRL, 1'b1, 1'b0, d);
    endtask
    task automatic rdl(input logic [1:0] sel);
        lop(sel, 1'b0, 1'b0, 32'h0);
        apb(1'b0, host_port_pkg::OFS_RDATA, 32'h0);
    endtask
    task automatic cpu(input logic [3:0] s, input logic [31:0] d);
        cpu_wr <= 1'b1;
        cpu_wstrb <= s;
        cpu_wdata <= d;
        @(posedge pclk);
        cpu_wr <= 1'b0;
        @(posedge pclk);
    endtask
    // Software handshake: wait on the ready pin as the host would, not on the memory side
    task automatic idle();
        do apb(1'b0, host_port_pkg::OFS_STATUS, 32'h0); while (q[host_port_pkg::ST_READY_BIT] !== 1'b1);
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(cpu_rdata, 32'h0000_0008);
        chk({31'h0, lnk.device_to_host_irq_n}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk({30'h0, pready, pslverr}, 32'h2);
        apb(1'b1, host_port_pkg::OFS_CONFIG, 32'h0000_0003);
        cpu(4'he, 32'h0000_0004);
        chk({31'h0, lnk.device_to_host_irq_n}, 32'h1);
        cpu(4'h1, 32'h0000_0004);
        chk({31'h0, lnk.device_to_host_irq_n}, 32'h0);
        apb(1'b0, host_port_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, q[host_port_pkg::ST_IRQ_BIT]}, 32'h1);
        rdl(host_port_pkg::SEL_CTRL);
        chk(q, 32'h000c_000c);
        wctl(32'h0);
        cpu(4'h1, 32'h0);
        chk({31'h0, lnk.device_to_host_irq_n}, 32'h0);
        wctl(32'h0004_0004);
        chk({31'h0, lnk.device_to_host_irq_n}, 32'h1);
        cpu(4'h1, 32'h0000_0002);
        chk({31'h0, host_to_core_irq}, 32'h0);
        wctl(32'h0002_0002);
        chk({31'h0, host_to_core_irq}, 32'h1);
        wctl(32'h0);
        cpu(4'h1, 32'h0);
        chk({31'h0, host_to_core_irq}, 32'h1);
        cpu(4'h1, 32'h0000_0002);
        chk({31'h0, host_to_core_irq}, 32'h0);
        lop(host_port_pkg::SEL_ADDR, 1'b1, 1'b0, 32'h0000_0100);
        wctl(32'h0010_0010);
        chk(cpu_rdata, 32'h0000_0000);
        chk({31'h0, lnk.host_ready}, 32'h0);
        idle();
        rdl(host_port_pkg::SEL_DATA);
        chk(q, 32'ha5a5_0100);
        idle();
        apb(1'b1, host_port_pkg::OFS_CONFIG, 32'h0000_0002);
        for (int o = 0; o < 2; o++) begin
            wctl({31'h0, o[0]});
            lop(host_port_pkg::SEL_DATA, 1'b1, 1'b0, 32'h0000_1234);
            lop(host_port_pkg::SEL_DATA, 1'b1, 1'b1, 32'h0000_5678);
            idle();
            chk(cap, o[0] ? 32'h5678_1234 : 32'h1234_5678);
        end
        rdl(host_port_pkg::SEL_CTRL);
        chk(q, 32'h0000_0009);
        cpu(4'h1, 32'h0000_0004);
        lop(host_port_pkg::SEL_CTRL, 1'b0, 1'b1, 32'h0);
        apb(1'b0, host_port_pkg::OFS_RDATA, 32'h0);
        chk(q, 32'h0000_000d);
        wctl(32'h0000_0005);
        // Core write lands on the strobe edge, six edges into the link write
        fork
            wctl(32'h0000_0003);
            begin
                repeat (5) @(posedge pclk);
                cpu(4'h1, 32'h0000_0004);
            end
        join
        chk({30'h0, host_to_core_irq, lnk.device_to_host_irq_n}, 32'h2);
        // Opposing writes in one cycle: the set must win on both bits
        fork
            wctl(32'h0000_0007);
            begin
                repeat (5) @(posedge pclk);
                cpu(4'h1, 32'h0000_0006);
            end
        join
        chk({30'h0, host_to_core_irq, lnk.device_to_host_irq_n}, 32'h2);
        // Order stays at one here, so full width must ignore it
        apb(1'b1, host_port_pkg::OFS_CONFIG, 32'h0000_0003);
        lop(host_port_pkg::SEL_DATA, 1'b1, 1'b0, 32'hcafe_f00d);
        idle();
        chk(cap, 32'hcafe_f00d);
        lop(host_port_pkg::SEL_ADDR, 1'b1, 1'b0, 32'h0000_0200);
        wctl(32'h0011_0011);
        idle();
        rdl(host_port_pkg::SEL_DATA_INC);
        chk(q, 32'ha5a5_0200);
        idle();
        rdl(host_port_pkg::SEL_DATA);
        chk(q, 32'ha5a5_0204);
        rdl(host_port_pkg::SEL_ADDR);
        chk(q, 32'h0000_0204);
        // Reset in mid-run with both interrupt bits still set
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({30'h0, host_to_core_irq, lnk.device_to_host_irq_n}, 32'h1);
        chk(cpu_rdata, 32'h0000_0008);
        tally_and_finish();
    end
endmodule
`default_nettype wire
